// ==== pkg/exec_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// Handshake between step controller and instruction sequencer
interface exec_if;
  logic issue;   // Issue permission for the coming cycle
  logic retire;  // Sequencer completed an instruction
  modport ctrl (output issue, input retire);
  modport seq  (input issue, output retire);
endinterface
`default_nettype wire

// ==== pkg/step_ctrl_pkg.sv ====
`default_nettype none
package step_ctrl_pkg;
  localparam int          ADDR_W          = 4;
  localparam int          DATA_W          = 32;
  // Register offsets
  localparam logic [3:0]  ADDR_CTRL       = 4'h0;
  localparam logic [3:0]  ADDR_IRQ_STAT   = 4'h4;
  localparam logic [3:0]  ADDR_IRQ_MASK   = 4'h8;
  // Control bit positions
  localparam int          BIT_FORCE_IRQ   = 2;
  localparam int          BIT_STEP_EN     = 3;
  localparam int          BIT_STEP_GO     = 4;
  localparam int          BIT_SPARE       = 5;
  // Interrupt status bit positions
  localparam int          IRQ_FORCED      = 0;
  localparam int          IRQ_HALTED      = 1;
  localparam int          IRQ_W           = 2;
  localparam logic [1:0]  IRQ_RST         = 2'h0;
  localparam logic [31:0] DATA_ZERO       = 32'h0000_0000;
endpackage
`default_nettype wire

// ==== src/step_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Writing one to control bit 2 raises a type-zero interrupt.
// - Forced interrupt is a one-cycle pulse; its status bit, if unmasked, holds o_irq until written one.
// - Control bit 2 always reads zero.
// - Control bit 3 set enables single-step mode.
// - In step mode execution pauses after each instruction.
// - Bit 3 reads halted status, one only while waiting to advance.
// - Writing one to bit 4 while paused runs exactly one instruction.
// - Zero writes or advances while not paused have no effect.
// - Control bit 4 always reads zero.
module step_ctrl
  import step_ctrl_pkg::*;
(
  input  wire logic              i_core_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_ce,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  input  wire logic              i_run,
  input  wire logic              i_retire,
  output logic      [DATA_W-1:0] o_rdata,
  output logic                   o_issue,
  output logic                   o_force_irq_type_zero,
  output logic                   o_irq
);
  exec_if ex ();

  logic              step_en_ff;
  logic              force_ff;
  logic              go_ff;
  logic              issue_ff;
  logic              irq_ff;
  logic [IRQ_W-1:0]  stat_ff;
  logic [IRQ_W-1:0]  mask_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic              halted;
  logic              halted_q_ff;
  logic [IRQ_W-1:0]  nxt_stat;
  logic [DATA_W-1:0] nxt_rdata;
  logic              wr_ctrl;
  logic              wr_stat;
  logic              wr_mask;
  logic              nxt_force;
  logic              nxt_go;
  logic [IRQ_W-1:0]  events;

  // Address decode
  assign wr_ctrl = i_wr & (i_addr == ADDR_CTRL);
  assign wr_stat = i_wr & (i_addr == ADDR_IRQ_STAT);
  assign wr_mask = i_wr & (i_addr == ADDR_IRQ_MASK);

  // Command bits become single pulses, no stored level
  assign nxt_force = wr_ctrl & i_wdata[BIT_FORCE_IRQ];
  assign nxt_go    = wr_ctrl & i_wdata[BIT_STEP_GO];

  // Retire comes from the same clock, no synchroniser needed
  assign ex.retire = i_retire;

  step_gate u_gate (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_ce       (i_ce),
    .i_step_en  (step_en_ff),
    .i_go       (go_ff),
    .i_run      (i_run),
    .o_halted   (halted),
    .ex         (ex)
  );

  // Events: forced interrupt and entry into halt
  assign events[IRQ_FORCED] = force_ff;
  assign events[IRQ_HALTED] = halted & ~halted_q_ff;
  // Set wins over write-one-to-clear
  assign nxt_stat = (stat_ff & ~(wr_stat ? i_wdata[IRQ_W-1:0] : IRQ_RST))
                    | events;

  // Read mux; bits 2, 4, 5 read zero, bit 3 shows halted
  always_comb begin
    nxt_rdata = DATA_ZERO;
    if (i_rd) begin
      unique case (i_addr)
        ADDR_CTRL:     nxt_rdata[BIT_STEP_EN] = halted;
        ADDR_IRQ_STAT: nxt_rdata[IRQ_W-1:0]   = stat_ff;
        ADDR_IRQ_MASK: nxt_rdata[IRQ_W-1:0]   = mask_ff;
        default:       nxt_rdata = DATA_ZERO;
      endcase
    end
  end

  // Control and command pulses
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      step_en_ff <= 1'b0;
      force_ff   <= 1'b0;
      go_ff      <= 1'b0;
    end else if (i_ce) begin
      if (wr_ctrl) begin
        step_en_ff <= i_wdata[BIT_STEP_EN];
      end
      force_ff <= nxt_force;
      go_ff    <= nxt_go;
    end
  end

  // Interrupt, read data and registered outputs
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stat_ff     <= IRQ_RST;
      mask_ff     <= IRQ_RST;
      irq_ff      <= 1'b0;
      rdata_ff    <= DATA_ZERO;
      issue_ff    <= 1'b0;
      halted_q_ff <= 1'b0;
    end else if (i_ce) begin
      stat_ff     <= nxt_stat;
      if (wr_mask) begin
        mask_ff <= i_wdata[IRQ_W-1:0];
      end
      irq_ff      <= |(nxt_stat & mask_ff);
      rdata_ff    <= nxt_rdata;
      issue_ff    <= ex.issue;
      halted_q_ff <= halted;
    end
  end

  assign o_rdata               = rdata_ff;
  assign o_issue               = issue_ff;
  assign o_force_irq_type_zero = force_ff;
  assign o_irq                 = irq_ff;

  // Assertions
  property p_force_pulse;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_ce && wr_ctrl && i_wdata[BIT_FORCE_IRQ]) |=> o_force_irq_type_zero;
  endproperty
  a_force_pulse: assert property (p_force_pulse)
    else $error("force write gave no interrupt");

  property p_force_one_shot;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_ce && o_force_irq_type_zero && !nxt_force) |=> !o_force_irq_type_zero;
  endproperty
  a_force_one_shot: assert property (p_force_one_shot)
    else $error("forced interrupt held as level");

  property p_ctrl_read_zero;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_ce && i_rd && i_addr == ADDR_CTRL) |=>
        (o_rdata[BIT_FORCE_IRQ] == 1'b0 && o_rdata[BIT_STEP_GO] == 1'b0
         && o_rdata[BIT_SPARE] == 1'b0);
  endproperty
  a_ctrl_read_zero: assert property (p_ctrl_read_zero)
    else $error("command bit read nonzero");

  logic go_ok_a;
  assign go_ok_a = go_ff & halted;
  property p_halt_after_retire;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_ce && step_en_ff && ex.retire && !go_ok_a) |=> halted;
  endproperty
  a_halt_after_retire: assert property (p_halt_after_retire)
    else $error("no pause after instruction");

  property p_no_issue_halted;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (halted && !go_ff && step_en_ff) |-> !ex.issue;
  endproperty
  a_no_issue_halted: assert property (p_no_issue_halted)
    else $error("issue while halted");

  property p_read_halted;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_ce && i_rd && i_addr == ADDR_CTRL) |=>
        (o_rdata[BIT_STEP_EN] == $past(halted));
  endproperty
  a_read_halted: assert property (p_read_halted)
    else $error("bit 3 does not show halted");

  property p_go_frees;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_ce && halted && go_ff && step_en_ff && i_run) |-> ex.issue;
  endproperty
  a_go_frees: assert property (p_go_frees)
    else $error("go did not release one instruction");

  property p_no_step_no_halt;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_ce && !step_en_ff) |=> !halted;
  endproperty
  a_no_step_no_halt: assert property (p_no_step_no_halt)
    else $error("halted outside step mode");

  // Force command: zero writes stay quiet, events reach status and line
  property p_force_zero_quiet;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_ce && wr_ctrl && !i_wdata[BIT_FORCE_IRQ]) |=> !o_force_irq_type_zero;
  endproperty
  a_force_zero_quiet: assert property (p_force_zero_quiet)
    else $error("zero write raised interrupt");

  property p_force_sets_stat;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_ce && force_ff) |=> stat_ff[IRQ_FORCED];
  endproperty
  a_force_sets_stat: assert property (p_force_sets_stat)
    else $error("forced event lost from status");

  property p_irq_raise;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_ce && force_ff && mask_ff[IRQ_FORCED]) |=> o_irq;
  endproperty
  a_irq_raise: assert property (p_irq_raise)
    else $error("unmasked forced event gave no interrupt");

  property p_irq_masked;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_ce && mask_ff == IRQ_RST) |=> !o_irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("interrupt line high with all masked");

  // Step control: advance is honoured only while paused in step mode
  property p_go_zero_ignored;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_ce && wr_ctrl && !i_wdata[BIT_STEP_GO]) |=> !go_ff;
  endproperty
  a_go_zero_ignored: assert property (p_go_zero_ignored)
    else $error("zero write produced an advance");

  property p_go_one_shot;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_ce && go_ff && !nxt_go) |=> !go_ff;
  endproperty
  a_go_one_shot: assert property (p_go_one_shot)
    else $error("advance command held as level");

  property p_release_halt;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_ce && halted && go_ff && step_en_ff) |=> !halted;
  endproperty
  a_release_halt: assert property (p_release_halt)
    else $error("advance did not leave the pause");

  property p_halted_stays;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_ce && halted && step_en_ff && !go_ff) |=> halted;
  endproperty
  a_halted_stays: assert property (p_halted_stays)
    else $error("pause ended without advance");

  property p_go_running_ignored;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (go_ff && !halted && !ex.retire) |-> (ex.issue == i_run);
  endproperty
  a_go_running_ignored: assert property (p_go_running_ignored)
    else $error("advance while running changed issue");

  property p_issue_stops;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_ce && step_en_ff && ex.retire && !go_ff) |=> !o_issue;
  endproperty
  a_issue_stops: assert property (p_issue_stops)
    else $error("issue still granted after retire");

  property p_halt_sets_stat;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_ce && halted && !halted_q_ff) |=> stat_ff[IRQ_HALTED];
  endproperty
  a_halt_sets_stat: assert property (p_halt_sets_stat)
    else $error("halt entry lost from status");

  property p_step_en_write;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_ce && wr_ctrl) |=>
        (step_en_ff == $past(i_wdata[BIT_STEP_EN]));
  endproperty
  a_step_en_write: assert property (p_step_en_write)
    else $error("step enable not taken from write");

  // Enable low freezes state; read data idle at zero
  property p_ce_freeze;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      !i_ce |=>
        ($stable(step_en_ff) && $stable(halted) && $stable(o_irq));
  endproperty
  a_ce_freeze: assert property (p_ce_freeze)
    else $error("state moved while enable low");

  property p_rdata_idle;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_ce && !i_rd) |=> (o_rdata == DATA_ZERO);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data nonzero without read");

  c_force: cover property (@(posedge i_core_clk) o_force_irq_type_zero);
  c_halt:  cover property (@(posedge i_core_clk) $rose(halted));
  c_go:    cover property (@(posedge i_core_clk) halted && go_ff);
  c_irq:   cover property (@(posedge i_core_clk) o_irq);
  c_unstep: cover property (@(posedge i_core_clk) halted && !step_en_ff);
endmodule
`default_nettype wire

// ==== src/step_gate.sv ====
`timescale 1ns/1ps
`default_nettype none
// Decides when the sequencer may issue and tracks the halted state
module step_gate (
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  input  wire logic i_ce,
  input  wire logic i_step_en,
  input  wire logic i_go,
  input  wire logic i_run,
  output var  logic o_halted,
  exec_if.ctrl      ex
);
  logic halted_ff;
  logic nxt_halted;
  logic go_ok;

  // Go counts only while truly paused in step mode
  assign go_ok      = i_go & halted_ff & i_step_en;
  // Pause after each retired instruction while stepping
  assign nxt_halted = i_step_en & ~go_ok &
                      (halted_ff | ex.retire);
  // Permission for next cycle, so a registered copy drops at retire
  assign ex.issue   = i_run & ~nxt_halted;
  assign o_halted   = halted_ff;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      halted_ff <= 1'b0;
    end else if (i_ce) begin
      halted_ff <= nxt_halted;
    end
  end
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench import step_ctrl_pkg::*;;
  logic              clk;
  logic              rst_n;
  logic              ce;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr;
  logic              rd;
  logic              run;
  logic              retire;
  logic [DATA_W-1:0] rdata;
  logic              issue;
  logic              force_irq;
  logic              irq;
  logic [DATA_W-1:0] val;
  int                errors;
  int                compares;

  step_ctrl dut (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_run(run),
    .i_retire(retire), .o_rdata(rdata), .o_issue(issue),
    .o_force_irq_type_zero(force_irq), .o_irq(irq)
  );

  // Clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // One-cycle write; returns just after the edge that takes it
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  // Read data only stand in the cycle after the strobe
  task automatic bus_rd(input logic [3:0] a);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    val = rdata;
  endtask

  task automatic retire_one();
    @(posedge clk);
    retire <= 1'b1;
    @(posedge clk);
    retire <= 1'b0;
  endtask

  // Polls halted status, bounded so a stuck core ends the run
  task automatic wait_halted();
    for (int n = 0; n < 20; n++) begin
      bus_rd(ADDR_CTRL);
      if (val[BIT_STEP_EN] === 1'b1) return;
    end
    errors++;
    give_verdict();
  endtask

  task automatic force_scn();
    bus_wr(ADDR_IRQ_MASK, 32'h0000_0001);
    bus_wr(ADDR_CTRL, 32'h0000_0004);
    chk("force_pulse", 32'(force_irq), 32'h1);
    @(posedge clk);
    #1;
    chk("force_end", 32'(force_irq), 32'h0);
    chk("irq_on", 32'(irq), 32'h1);
    bus_rd(ADDR_CTRL);
    chk("ctrl_bit2", val, DATA_ZERO);
    bus_wr(ADDR_CTRL, DATA_ZERO);
    chk("force_zero_wr", 32'(force_irq), 32'h0);
    bus_rd(ADDR_CTRL);
    chk("ctrl_bit5", val, DATA_ZERO);
    bus_wr(ADDR_IRQ_STAT, 32'h0000_0001);
    @(posedge clk);
    #1;
    chk("irq_clr", 32'(irq), 32'h0);
    // Masked: status still records the event, line stays low
    bus_wr(ADDR_IRQ_MASK, DATA_ZERO);
    bus_wr(ADDR_CTRL, 32'h0000_0004);
    bus_rd(ADDR_IRQ_STAT);
    chk("stat_forced", val, 32'h0000_0001);
    chk("irq_masked", 32'(irq), 32'h0);
    bus_wr(ADDR_IRQ_STAT, 32'h0000_0001);
    // Enable low freezes the block, so a force write is lost
    @(posedge clk);
    ce <= 1'b0;
    bus_wr(ADDR_CTRL, 32'h0000_0004);
    chk("ce_frozen", 32'(force_irq), 32'h0);
    @(posedge clk);
    ce <= 1'b1;
  endtask

  task automatic step_scn();
    @(posedge clk);
    run <= 1'b1;
    bus_wr(ADDR_CTRL, 32'h0000_0008);
    retire_one();
    wait_halted();
    chk("ctrl_halted", val, 32'h0000_0008);
    repeat (3) begin
      @(posedge clk);
      #1;
      chk("issue_paused", 32'(issue), 32'h0);
    end
    // Go bit written as zero must not advance
    bus_wr(ADDR_CTRL, 32'h0000_0008);
    bus_rd(ADDR_CTRL);
    chk("go_zero", val, 32'h0000_0008);
    bus_wr(ADDR_CTRL, 32'h0000_0018);
    @(posedge clk);
    #1;
    chk("issue_go", 32'(issue), 32'h1);
    bus_rd(ADDR_CTRL);
    chk("ctrl_running", val, DATA_ZERO);
    retire_one();
    #1;
    chk("issue_stop", 32'(issue), 32'h0);
    wait_halted();
    chk("issue_again", 32'(issue), 32'h0);
    bus_rd(ADDR_IRQ_STAT);
    chk("stat_halt", val, 32'h0000_0002);
    // Leaving step mode releases the halt
    bus_wr(ADDR_CTRL, DATA_ZERO);
    bus_wr(ADDR_IRQ_STAT, 32'h0000_0002);
    bus_rd(ADDR_CTRL);
    chk("step_off", val, DATA_ZERO);
  endtask

  initial begin
    rst_n    = 1'b0;
    ce       = 1'b1;
    addr     = 4'h0;
    wdata    = DATA_ZERO;
    wr       = 1'b0;
    rd       = 1'b0;
    run      = 1'b0;
    retire   = 1'b0;
    errors   = 0;
    compares = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("rst_irq", 32'(irq), 32'h0);
    force_scn();
    step_scn();
    give_verdict();
  end
endmodule
`default_nettype wire
